// ---- inc/rvs_pkg.sv ----
package rvs_pkg;

  // register byte addresses on the serial interface
  localparam logic [7:0] CORE_ADDR = 8'h06;
  localparam logic [7:0] VSEL_ADDR = 8'h08;

  // serial device address; the value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h48;

  // field layout of the regulator voltage select register
  localparam int SECOND_LSB = 4;
  localparam int FIRST_LSB = 0;
  localparam logic [7:0] VSEL_RSVD_MASK = 8'h88;

  // core default code: top bit set, low four bits follow the strap
  localparam logic CORE_DEF_MSB = 1'b1;
  localparam logic [4:0] CORE_TOP_CODE = 5'h1F;

  // output voltages in millivolts
  localparam logic [11:0] SECOND_MV [8] = '{12'h41A, 12'h4B0, 12'h514,
    12'h708, 12'h9C4, 12'hAF0, 12'hBB8, 12'hCE4};
  localparam logic [11:0] FIRST_MV [8] = '{12'h3E8, 12'h44C, 12'h514,
    12'h708, 12'h898, 12'hA28, 12'hAF0, 12'hC4E};
  localparam logic [11:0] CORE_BASE_MV = 12'h320;
  localparam logic [11:0] CORE_STEP_MV = 12'h019;
  localparam logic [11:0] CORE_HI_MV = 12'h640;
  localparam logic [11:0] CORE_LO_MV = 12'h4B0;
  localparam logic [11:0] RAIL_HI_MV = 12'hCE4;
  localparam logic [11:0] RAIL_LO_MV = 12'h708;

  // linear defaults by strap pair {strap_b, strap_a}
  localparam logic [2:0] STRAP_SECOND [4] = '{3'h1, 3'h3, 3'h6, 3'h7};
  localparam logic [2:0] STRAP_FIRST [4] = '{3'h3, 3'h3, 3'h5, 3'h6};

  // clocks after reset release during which defaults keep loading
  localparam logic [1:0] BOOT_LOAD_CYCLES = 2'h3;

endpackage

// ---- logic/rvs_i2c_slave.sv ----
module rvs_i2c_slave (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic wr_en,
  output logic [7:0] ptr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);

  typedef enum logic [2:0] {IDLE, ADDR, PTR, WDATA, ACK, RDATA, RACK}
    rvs_i2c_e;

  rvs_i2c_e state; // bus transaction phase
  rvs_i2c_e after; // phase entered once the ack bit ends
  logic scl_m, scl_s, scl_d; // scl synchroniser and delayed copy
  logic sda_m, sda_s, sda_d; // sda synchroniser and delayed copy
  logic [7:0] shreg; // shift register for both directions
  logic [3:0] cnt; // bits seen in the current byte
  logic start, stop, rise, fall;

  // three flops per pin; the second stage and its delayed copy are looked at
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // bus conditions from synchronised levels
  assign start = scl_s & scl_d & sda_d & ~sda_s;
  assign stop = scl_s & scl_d & ~sda_d & sda_s;
  assign rise = scl_s & ~scl_d;
  assign fall = ~scl_s & scl_d;

  // open drain: the line is only ever pulled low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sda_out <= 1'b0;
    else sda_out <= 1'b0;
  end

  // transaction sequencer; sda only changes while scl is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= IDLE;
      after <= IDLE;
      shreg <= 8'h00;
      cnt <= 4'h0;
      sda_oe <= 1'b0;
      wr_en <= 1'b0;
      ptr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start) begin
        // a repeated start keeps the pointer for a combined read
        state <= ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        state <= IDLE;
        sda_oe <= 1'b0;
      end else if (rise) begin
        unique case (state)
          ADDR, PTR, WDATA: begin
            shreg <= {shreg[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          RDATA: cnt <= cnt + 4'h1;
          RACK: if (sda_s) state <= IDLE; // master nack ends the read
          IDLE, ACK: ;
        endcase
      end else if (fall) begin
        unique case (state)
          ADDR: if (cnt == 4'h8) begin
            if (shreg[7:1] == rvs_pkg::DEV_ADDR) begin
              sda_oe <= 1'b1;
              after <= shreg[0] ? RDATA : PTR;
              state <= ACK;
            end else begin
              state <= IDLE; // another device's address
            end
          end
          PTR: if (cnt == 4'h8) begin
            ptr <= shreg;
            sda_oe <= 1'b1;
            after <= WDATA;
            state <= ACK;
          end
          WDATA: if (cnt == 4'h8) begin
            // pointer does not advance; every byte hits one register
            wr_en <= 1'b1;
            wr_data <= shreg;
            sda_oe <= 1'b1;
            after <= WDATA;
            state <= ACK;
          end
          ACK: begin
            cnt <= 4'h0;
            state <= after;
            if (after == RDATA) begin
              shreg <= rd_data;
              sda_oe <= ~rd_data[7];
            end else begin
              sda_oe <= 1'b0;
            end
          end
          RDATA: if (cnt == 4'h8) begin
            sda_oe <= 1'b0;
            state <= RACK;
          end else begin
            sda_oe <= ~shreg[6];
            shreg <= {shreg[6:0], 1'b0};
          end
          RACK: begin
            cnt <= 4'h0;
            shreg <= rd_data;
            sda_oe <= ~rd_data[7];
            state <= RDATA;
          end
          IDLE: ;
        endcase
      end
    end
  end

endmodule // rvs_i2c_slave

// ---- logic/rvs_regs.sv ----
// Behaviour
// - bits 6..4 select second regulator voltage
// - bits 2..0 select first regulator voltage
// - lockout loads both codes from strap pins
// - core starts 1.6 V high, 1.2 V low
// - other converters start 3.3 V or 1.8 V
// - changed core register overrides core strap
// - core code is 0.8 V plus 25 mV steps, top code pinned to 1.6 V
module rvs_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic undervoltage_lockout,
  input wire logic linear_default_strap_a,
  input wire logic linear_default_strap_b,
  input wire logic core_default_strap,
  input wire logic core_divider_present,
  input wire logic system_default_strap,
  input wire logic memory_default_strap,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [2:0] first_reg_code,
  output logic [2:0] second_reg_code,
  output logic [11:0] first_linear_regulator_mv,
  output logic [11:0] second_linear_regulator_mv,
  output logic [4:0] core_voltage_code,
  output logic core_register_override,
  output logic core_divider_mode,
  output logic [11:0] core_converter_output_mv,
  output logic [11:0] system_converter_mv,
  output logic [11:0] memory_converter_mv
);

  logic [6:0] pin_m; // first synchroniser stage of the pins
  logic [6:0] pin_s; // second stage, safe to use
  logic lockout, strap_a, strap_b, strap_core, divider, strap_sys, strap_mem;
  logic [1:0] boot_cnt; // keeps defaults loading after reset release
  logic load_def; // load strap defaults this cycle
  logic wr_en; // one cycle register write from the serial port
  logic [7:0] ptr; // register pointer
  logic [7:0] wr_data;
  logic [7:0] rd_data; // read mux, reserved bits forced low
  logic [4:0] core_def; // strap derived core default
  logic [2:0] def_first, def_second;
  logic [11:0] core_reg_mv; // register decoded core voltage

  // two flops for every strap and the lockout pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_m <= 7'h00;
      pin_s <= 7'h00;
    end else begin
      pin_m <= {undervoltage_lockout, linear_default_strap_a,
                linear_default_strap_b, core_default_strap,
                core_divider_present, system_default_strap,
                memory_default_strap};
      pin_s <= pin_m;
    end
  end

  assign {lockout, strap_a, strap_b, strap_core, divider, strap_sys,
          strap_mem} = pin_s;

  // synchronisers need two edges, so load for a few cycles after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) boot_cnt <= rvs_pkg::BOOT_LOAD_CYCLES;
    else if (boot_cnt != 2'h0) boot_cnt <= boot_cnt - 2'h1;
  end

  assign load_def = lockout | (boot_cnt != 2'h0);
  assign def_first = rvs_pkg::STRAP_FIRST[{strap_b, strap_a}];
  assign def_second = rvs_pkg::STRAP_SECOND[{strap_b, strap_a}];
  assign core_def = {rvs_pkg::CORE_DEF_MSB, {4{strap_core}}};

  rvs_i2c_slave u_port (
    .clk(clk),
    .rstn(rstn),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_en(wr_en),
    .ptr(ptr),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // linear regulator codes; lockout wins over a write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_reg_code <= 3'h0;
      second_reg_code <= 3'h0;
    end else if (load_def) begin
      first_reg_code <= def_first;
      second_reg_code <= def_second;
    end else if (wr_en && ptr == rvs_pkg::VSEL_ADDR) begin
      // written reserved bits are dropped here, not stored
      second_reg_code <= wr_data[rvs_pkg::SECOND_LSB +: 3];
      first_reg_code <= wr_data[rvs_pkg::FIRST_LSB +: 3];
    end
  end

  // core code register and its override flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_voltage_code <= 5'h00;
      core_register_override <= 1'b0;
    end else if (load_def) begin
      core_voltage_code <= core_def;
      core_register_override <= 1'b0;
    end else if (wr_en && ptr == rvs_pkg::CORE_ADDR) begin
      core_voltage_code <= wr_data[4:0];
      // rewriting the default keeps strap control
      if (wr_data[4:0] != core_def) core_register_override <= 1'b1;
    end
  end

  // read mux; reserved positions are constant zero
  always_comb begin
    rd_data = 8'h00;
    if (ptr == rvs_pkg::VSEL_ADDR) begin
      rd_data[rvs_pkg::SECOND_LSB +: 3] = second_reg_code;
      rd_data[rvs_pkg::FIRST_LSB +: 3] = first_reg_code;
      rd_data = rd_data & ~rvs_pkg::VSEL_RSVD_MASK;
    end else if (ptr == rvs_pkg::CORE_ADDR) begin
      rd_data[4:0] = core_voltage_code;
    end
  end

  // top code is pinned to the documented maximum, not the linear value
  assign core_reg_mv = (core_voltage_code == rvs_pkg::CORE_TOP_CODE)
    ? rvs_pkg::CORE_HI_MV
    : rvs_pkg::CORE_BASE_MV
      + 12'(core_voltage_code) * rvs_pkg::CORE_STEP_MV;

  // registered voltage outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_linear_regulator_mv <= 12'h000;
      second_linear_regulator_mv <= 12'h000;
      core_converter_output_mv <= 12'h000;
      system_converter_mv <= 12'h000;
      memory_converter_mv <= 12'h000;
      core_divider_mode <= 1'b0;
    end else begin
      first_linear_regulator_mv <= rvs_pkg::FIRST_MV[first_reg_code];
      second_linear_regulator_mv <=
        rvs_pkg::SECOND_MV[second_reg_code];
      if (core_register_override) begin
        core_converter_output_mv <= core_reg_mv;
      end else begin
        core_converter_output_mv <= strap_core ? rvs_pkg::CORE_HI_MV
                                               : rvs_pkg::CORE_LO_MV;
      end
      // a divider only matters while the strap still rules the core
      core_divider_mode <= divider & ~core_register_override;
      system_converter_mv <= strap_sys ? rvs_pkg::RAIL_HI_MV
                                       : rvs_pkg::RAIL_LO_MV;
      memory_converter_mv <= strap_mem ? rvs_pkg::RAIL_HI_MV
                                       : rvs_pkg::RAIL_LO_MV;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  // the first edge after release still shows reset values, so skip it
  second_decode_a: assert property (
    $past(rstn) |-> second_linear_regulator_mv
      == rvs_pkg::SECOND_MV[$past(second_reg_code)])
    else $error("second regulator voltage mismatch");
  first_decode_a: assert property (
    $past(rstn) |-> first_linear_regulator_mv
      == rvs_pkg::FIRST_MV[$past(first_reg_code)])
    else $error("first regulator voltage mismatch");
  lockout_load_a: assert property (
    lockout |=> first_reg_code == $past(def_first)
      && second_reg_code == $past(def_second))
    else $error("lockout did not load strap defaults");
  core_strap_a: assert property (
    !core_register_override && strap_core && !lockout
      ##1 !core_register_override |-> core_converter_output_mv == 12'h640)
    else $error("core start voltage wrong");
  rail_strap_a: assert property (
    $past(rstn) |->
      system_converter_mv == ($past(strap_sys) ? 12'hCE4 : 12'h708)
      && memory_converter_mv == ($past(strap_mem) ? 12'hCE4 : 12'h708))
    else $error("rail start voltage wrong");
  core_override_a: assert property (
    wr_en && ptr == rvs_pkg::CORE_ADDR && !load_def
      && wr_data[4:0] != core_def |=> core_register_override
      ##1 core_converter_output_mv == core_reg_mv)
    else $error("core override not taken");
  core_step_a: assert property (
    core_register_override && core_voltage_code == 5'h00
      |=> core_converter_output_mv == 12'h320)
    else $error("core code zero not 800 mV");
  rsvd_zero_a: assert property (
    ptr == rvs_pkg::VSEL_ADDR |-> (rd_data & 8'h88) == 8'h00)
    else $error("reserved bits read nonzero");

  cover property (wr_en && ptr == rvs_pkg::VSEL_ADDR && !load_def);
  cover property (core_register_override && core_voltage_code == 5'h1F);
  cover property (lockout ##1 !lockout);
  cover property ($fell(sda_oe) && ptr == rvs_pkg::VSEL_ADDR);

endmodule // rvs_regs

// ---- tb/rvs_host_model.sv ----
// i2c host standing on the far side of the serial pins
module rvs_host_model (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull; // high while the host pulls the data line low
  // open drain with pull-up: the line is low if either party pulls
  assign sda_line = ~(pull | sda_oe);
  // bus idle at time zero
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // whole clocks only, so every change lands just after an edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves while scl is low; 10 clocks a phase beats the 8 needed
  task automatic bit_io(input logic b, output logic r);
    pull <= ~b;
    hold(10);
    scl <= 1'b1;
    hold(10);
    r = sda_line;
    scl <= 1'b0;
    hold(2);
  endtask
  // start condition, also serves as repeated start
  task automatic start();
    pull <= 1'b0;
    hold(10);
    scl <= 1'b1;
    hold(10);
    pull <= 1'b1;
    hold(10);
    scl <= 1'b0;
    hold(2);
  endtask
  // stop: data rises while scl is high
  task automatic stop();
    pull <= 1'b1;
    hold(10);
    scl <= 1'b1;
    hold(10);
    pull <= 1'b0;
    hold(10);
  endtask
  // msb first, then the ack slot with the host released
  task automatic io_byte(input logic [7:0] d, output logic [7:0] q,
    output logic k);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      q = {q[6:0], b};
    end
    bit_io(1'b1, k);
  endtask
  // one register write or read; raw lets a test send reserved ones
  task automatic txn(input logic [6:0] a, input logic [7:0] p,
    input logic [7:0] d, input logic rd, input logic raw,
    output logic [7:0] q, output logic ack);
    logic [7:0] junk;
    logic k;
    start();
    io_byte({a, 1'b0}, junk, k);
    ack = ~k;
    io_byte(p, junk, k);
    if (rd) begin
      start();
      io_byte({a, 1'b1}, junk, k);
      io_byte(8'hFF, q, k);
    end else begin
      if (!raw && p == rvs_pkg::VSEL_ADDR)
        d = d & ~rvs_pkg::VSEL_RSVD_MASK;
      io_byte(d, junk, k);
    end
    stop();
  endtask
endmodule // rvs_host_model

// ---- tb/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, lockout, strap_a, strap_b, strap_core, divider;
  logic strap_sys, strap_mem, scl, sda_oe, ack, override, div_mode;
  logic sda_drv; // data level driven while the enable is high
  wire logic sda_line;
  logic [2:0] first_code, second_code;
  logic [11:0] first_mv, second_mv, core_mv, sys_mv, mem_mv, exp_mv;
  logic [4:0] core_code;
  logic [7:0] q; // last byte read back
  int n_errors = 0;
  int n_compared = 0;
  // rail voltages per code, in millivolts
  localparam logic [11:0] FIRST_EXP [8] = '{12'h3E8, 12'h44C, 12'h514,
    12'h708, 12'h898, 12'hA28, 12'hAF0, 12'hC4E};
  localparam logic [11:0] SECOND_EXP [8] = '{12'h41A, 12'h4B0, 12'h514,
    12'h708, 12'h9C4, 12'hAF0, 12'hBB8, 12'hCE4};
  // core codes: both ends of the range and two inside
  localparam logic [4:0] CORE_SET [4] = '{5'h00, 5'h0A, 5'h10, 5'h1F};

  rvs_host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl),
    .sda_line(sda_line));
  rvs_regs dut (.clk(clk), .rstn(rstn), .undervoltage_lockout(lockout),
    .linear_default_strap_a(strap_a), .linear_default_strap_b(strap_b),
    .core_default_strap(strap_core), .core_divider_present(divider),
    .system_default_strap(strap_sys), .memory_default_strap(strap_mem),
    .scl(scl), .sda_in(sda_line), .sda_out(sda_drv), .sda_oe(sda_oe),
    .first_reg_code(first_code), .second_reg_code(second_code),
    .first_linear_regulator_mv(first_mv),
    .second_linear_regulator_mv(second_mv),
    .core_voltage_code(core_code), .core_register_override(override),
    .core_divider_mode(div_mode), .core_converter_output_mv(core_mv),
    .system_converter_mv(sys_mv), .memory_converter_mv(mem_mv));

  // 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // compare and count; case inequality so unknowns never match
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d,
    input logic raw);
    host.txn(rvs_pkg::DEV_ADDR, p, d, 1'b0, raw, q, ack);
    chk({11'h000, ack}, 12'h001);
  endtask
  task automatic rd(input logic [7:0] p);
    host.txn(rvs_pkg::DEV_ADDR, p, 8'h00, 1'b1, 1'b0, q, ack);
    chk({11'h000, ack}, 12'h001);
  endtask
  // lockout held long enough to pass the 2-flop synchroniser
  task automatic lock_pulse();
    @(posedge clk);
    lockout <= 1'b1;
    repeat (6) @(posedge clk);
    lockout <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic final_report();
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // the tests need about 20000 clocks; three times that means a hang
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report();
  end

  initial begin
    {rstn, lockout, strap_a, strap_b, strap_core, strap_sys} = '0;
    strap_mem = 1'b0;
    divider = 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    // boot defaults with both linear straps low and core strap low
    chk({9'h000, first_code}, {9'h000, rvs_pkg::STRAP_FIRST[0]});
    chk({9'h000, second_code}, {9'h000, rvs_pkg::STRAP_SECOND[0]});
    chk(core_mv, 12'h4B0);
    // every code of both fields, then read back
    for (int c = 0; c < 8; c++) begin
      wr(rvs_pkg::VSEL_ADDR, {1'b0, 3'(c), 1'b0, 3'(7 - c)}, 1'b0);
      chk({9'h000, second_code}, 12'(c));
      chk(second_mv, SECOND_EXP[c]);
      chk({9'h000, first_code}, 12'(7 - c));
      chk(first_mv, FIRST_EXP[7 - c]);
      rd(rvs_pkg::VSEL_ADDR);
      chk({4'h0, q}, {5'h00, 3'(c), 1'b0, 3'(7 - c)});
    end
    // reserved ones sent on purpose must never read back
    wr(rvs_pkg::VSEL_ADDR, 8'hFF, 1'b1);
    rd(rvs_pkg::VSEL_ADDR);
    chk({4'h0, q}, 12'h077);
    // open drain: the driven level is always low
    chk({11'h000, sda_drv}, 12'h000);
    // an unmapped pointer reads as zero
    rd(8'h07);
    chk({4'h0, q}, 12'h000);
    // a foreign address gets no ack and changes nothing
    host.txn(rvs_pkg::DEV_ADDR ^ 7'h01, rvs_pkg::VSEL_ADDR, 8'h00, 1'b0,
      1'b0, q, ack);
    chk({11'h000, ack}, 12'h000);
    chk({9'h000, first_code}, 12'h007);
    // lockout beats the written values; every strap pair
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {strap_b, strap_a} <= 2'(i);
      strap_core <= i[0];
      strap_sys <= i[1];
      strap_mem <= ~i[1];
      divider <= i[0];
      lock_pulse();
      chk({9'h000, first_code}, {9'h000, rvs_pkg::STRAP_FIRST[i]});
      chk({9'h000, second_code}, {9'h000, rvs_pkg::STRAP_SECOND[i]});
      chk(first_mv, FIRST_EXP[rvs_pkg::STRAP_FIRST[i]]);
      chk(core_mv, i[0] ? 12'h640 : 12'h4B0);
      chk({7'h00, core_code}, {7'h00, 1'b1, {4{i[0]}}});
      chk(sys_mv, i[1] ? 12'hCE4 : 12'h708);
      chk(mem_mv, i[1] ? 12'h708 : 12'hCE4);
      chk({10'h000, override, div_mode}, 12'(i[0]));
    end
    // writing the default itself does not take the core over
    wr(rvs_pkg::CORE_ADDR, 8'h1F, 1'b0);
    chk({11'h000, override}, 12'h000);
    for (int k = 0; k < 4; k++) begin
      // top three bits set on purpose; they must be dropped
      wr(rvs_pkg::CORE_ADDR, {3'h7, CORE_SET[k]}, 1'b0);
      exp_mv = 12'h320 + 12'h019 * 12'(CORE_SET[k]);
      if (CORE_SET[k] == 5'h1F) exp_mv = 12'h640;
      chk({7'h00, core_code}, {7'h00, CORE_SET[k]});
      chk(core_mv, exp_mv);
      chk({10'h000, override, div_mode}, 12'h002);
    end
    // strap moves after takeover: the register still rules
    @(posedge clk);
    strap_core <= 1'b0;
    repeat (8) @(posedge clk);
    chk(core_mv, 12'h640);
    rd(rvs_pkg::CORE_ADDR);
    chk({4'h0, q}, 12'h01F);
    final_report();
  end
endmodule // tb_top
